// ---- core/eii_pkg.sv ----
package eii_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    // The high-frequency clock is the system clock itself (250 MHz)
    localparam int CLK_PERIOD_NS = 4;
    localparam int FC_PERIOD_NS = 4;
    localparam int CLK_PER_FC = FC_PERIOD_NS / CLK_PERIOD_NS;

    // Rejection thresholds, in high-frequency clock periods
    localparam int REJ_ZERO_FIVE_FC = 2;
    localparam int REJ_ONE_SHORT_FC = 15;
    localparam int REJ_ONE_LONG_FC = 63;
    localparam int REJ_THREE_FOUR_FC = 7;
    // Rejection threshold in low-frequency clock periods, sampled on ticks
    localparam int REJ_SLOW_FS = 2;

    localparam int FILT_CNT_W = 8;
    localparam logic [FILT_CNT_W-1:0] REJ_ZERO_FIVE_CYC = FILT_CNT_W'(REJ_ZERO_FIVE_FC * CLK_PER_FC);
    localparam logic [FILT_CNT_W-1:0] REJ_ONE_SHORT_CYC = FILT_CNT_W'(REJ_ONE_SHORT_FC * CLK_PER_FC);
    localparam logic [FILT_CNT_W-1:0] REJ_ONE_LONG_CYC = FILT_CNT_W'(REJ_ONE_LONG_FC * CLK_PER_FC);
    localparam logic [FILT_CNT_W-1:0] REJ_THREE_FOUR_CYC = FILT_CNT_W'(REJ_THREE_FOUR_FC * CLK_PER_FC);
    localparam logic [FILT_CNT_W-1:0] REJ_SLOW_TICKS = FILT_CNT_W'(REJ_SLOW_FS);

    // ------------------------------------------------------------
    // Register map (offsets are word indices, byte address = 4 * index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] CTRL_IDX = 8'h37;
    localparam logic [7:0] LATCH_IDX = 8'h3c;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] LATCH_ADDR = {LATCH_IDX, 2'b00};
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] LATCH_RESET = 5'h0;

    localparam int NUM_SRC = 5;
    // Source slots within the latch vector
    localparam int SRC_ZERO = 0;
    localparam int SRC_ONE = 1;
    localparam int SRC_THREE = 2;
    localparam int SRC_FOUR = 3;
    localparam int SRC_FIVE = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EII_TRIG_RISE = 2'b00,
        EII_TRIG_FALL = 2'b01,
        EII_TRIG_BOTH = 2'b10,
        EII_TRIG_HIGH = 2'b11
    } eii_trig_e;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic irq_one_filter_select;
        logic shared_pin_function_select;
        logic [1:0] irq_three_trigger_select;
        logic [1:0] irq_four_trigger_select;
        logic irq_one_trigger_select;
        logic unused;
    } eii_ctrl_s;

    // Enable flags from the CPU interrupt logic
    typedef struct packed {
        logic master_interrupt_enable;
        logic enable_flag_irq_zero;
        logic enable_flag_irq_one;
        logic enable_flag_irq_three;
        logic enable_flag_irq_four;
        logic enable_flag_irq_five;
        logic shared_level_source_select;
    } eii_enables_s;

endpackage : eii_pkg

// ---- core/eii_noise_filter.sv ----
`timescale 1ns/100ps
`default_nettype none

module eii_noise_filter
    import eii_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic sample_en_i,
    input wire logic [FILT_CNT_W-1:0] thresh_i,
    output logic filt_o,
    output logic valid_o
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic meta_q;
    logic sync_q;
    logic filt_q;
    logic valid_q;
    logic [FILT_CNT_W-1:0] cnt_q;

    // Two stages; only the second one is looked at. Kept out of reset so
    // they already hold the pin level when the filter primes after reset,
    // otherwise a pin high at release would look like a rising edge
    always_ff @(posedge clk_i) begin
        meta_q <= pin_i;
        sync_q <= meta_q;
    end

    // ------------------------------------------------------------
    // Stability counter
    // ------------------------------------------------------------
    // First sample after reset primes the output without an edge, so a
    // pin already high at release is not seen as a rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_q <= 1'b0;
            valid_q <= 1'b0;
            cnt_q <= '0;
        end else if (!valid_q) begin
            filt_q <= sync_q;
            valid_q <= 1'b1;
        end else if (sync_q == filt_q) begin
            cnt_q <= '0;
        end else if (sample_en_i) begin
            // Threshold compared live, so a new setting acts at once
            if (cnt_q + FILT_CNT_W'(1) >= thresh_i) begin
                filt_q <= sync_q;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + FILT_CNT_W'(1);
            end
        end
    end

    assign filt_o = filt_q;
    assign valid_o = valid_q;

endmodule : eii_noise_filter

`default_nettype wire

// ---- core/eii_trigger_detect.sv ----
`timescale 1ns/100ps
`default_nettype none

module eii_trigger_detect
    import eii_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic filt_i,
    input wire logic valid_i,
    input wire eii_trig_e mode_i,
    output logic event_o
);

    // ------------------------------------------------------------
    // Edge and level detection on the filtered signal
    // ------------------------------------------------------------
    logic prev_q;
    logic prev_valid_q;
    logic armed_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            prev_valid_q <= 1'b0;
        end else begin
            prev_q <= filt_i;
            prev_valid_q <= valid_i;
        end
    end

    assign rise = prev_valid_q & filt_i & ~prev_q;
    assign fall = prev_valid_q & ~filt_i & prev_q;

    // Level mode waits for one rising edge after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (rise) begin
            armed_q <= 1'b1;
        end
    end

    always_comb begin
        case (mode_i)
            EII_TRIG_RISE: event_o = rise;
            EII_TRIG_FALL: event_o = fall;
            EII_TRIG_BOTH: event_o = rise | fall;
            EII_TRIG_HIGH: event_o = filt_i & armed_q;
            default: event_o = 1'b0;
        endcase
    end

endmodule : eii_trigger_detect

`default_nettype wire

// ---- core/eii_top.sv ----
// Notes on behaviour
// - Five inputs, each noise filtered before detection
// - Shared pin is port after reset
// - Function select: 0 port, 1 interrupt zero
// - Select 0 blocks latch zero on falling edge
// - Inputs zero, five: falling, reject 2, accept 7
// - Slow modes: reject 1 fs, accept 3.5
// - Input one: 15/49 or 63/193 settings
// - Filter select 0 means 63, 1 means 15
// - Filter change acts within 26 periods
// - Inputs three, four: reject 7, accept 25
// - Trigger field: rise, fall, both, high level
// - Input one rise/fall bit; zero, five fixed
// - Requests gated by master and own enables
// - Input zero also needs function select
// - Latch set within acceptance plus 6 fs
// - High level needs rising edge after reset
// - Control resets to zero, low bit undefined
// - Latch holds until accepted or cleared
`timescale 1ns/100ps
`default_nettype none

module eii_top
    import eii_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External interrupt pins
    input wire logic ext_irq_zero_i,
    input wire logic ext_irq_one_i,
    input wire logic ext_irq_three_i,
    input wire logic ext_irq_four_i,
    input wire logic ext_irq_five_i,
    // Operating mode and low-frequency clock tick
    input wire logic low_speed_mode_i,
    input wire logic low_freq_tick_i,
    // CPU interrupt side
    input wire eii_enables_s enables_i,
    input wire logic [NUM_SRC-1:0] accept_i,
    output logic [NUM_SRC-1:0] latch_o,
    output logic [NUM_SRC-1:0] request_o,
    output logic shared_pin_function_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Byte address decode, used for both reads and writes
    function automatic logic hit(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] reg_addr);
        hit = (adr == reg_addr);
    endfunction : hit

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    eii_ctrl_s ctrl_q;
    logic [NUM_SRC-1:0] latch_q;
    logic [NUM_SRC-1:0] latch_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic bus_req;
    logic wr_strobe;
    logic [NUM_SRC-1:0] sw_clear;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_strobe = bus_req & wb_we_i & wb_sel_i[0];

    // Single wait-state answer: ack one cycle after the request, then drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Control register; the low bit is not stored and reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= eii_ctrl_s'(CTRL_RESET);
        end else if (wr_strobe && hit(wb_adr_i, CTRL_ADDR)) begin
            ctrl_q <= eii_ctrl_s'({wb_dat_i[7:1], 1'b0});
        end
    end

    // Read data registered with the ack; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            if (hit(wb_adr_i, CTRL_ADDR)) begin
                rdata_q <= {24'h00_0000, ctrl_q};
            end else if (hit(wb_adr_i, LATCH_ADDR)) begin
                rdata_q <= {27'h000_0000, latch_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Write one to a latch bit clears it
    assign sw_clear = (wr_strobe && hit(wb_adr_i, LATCH_ADDR)) ? wb_dat_i[NUM_SRC-1:0] : '0;

    // ------------------------------------------------------------
    // Filter thresholds
    // ------------------------------------------------------------
    logic [FILT_CNT_W-1:0] thresh [NUM_SRC];
    logic [NUM_SRC-1:0] pins;
    logic [NUM_SRC-1:0] filt;
    logic [NUM_SRC-1:0] valid;
    logic [NUM_SRC-1:0] trig_event;
    eii_trig_e mode [NUM_SRC];
    logic sample_en;
    logic [FILT_CNT_W-1:0] one_thresh;

    assign pins = {ext_irq_five_i, ext_irq_four_i, ext_irq_three_i, ext_irq_one_i, ext_irq_zero_i};

    // In slow and sleep modes every filter counts low-frequency ticks
    assign sample_en = low_speed_mode_i ? low_freq_tick_i : 1'b1;

    // Selection is combinational, so a new setting applies next sample
    assign one_thresh = ctrl_q.irq_one_filter_select ? REJ_ONE_SHORT_CYC : REJ_ONE_LONG_CYC;

    always_comb begin
        if (low_speed_mode_i) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                thresh[i] = REJ_SLOW_TICKS;
            end
        end else begin
            thresh[SRC_ZERO] = REJ_ZERO_FIVE_CYC;
            thresh[SRC_ONE] = one_thresh;
            thresh[SRC_THREE] = REJ_THREE_FOUR_CYC;
            thresh[SRC_FOUR] = REJ_THREE_FOUR_CYC;
            thresh[SRC_FIVE] = REJ_ZERO_FIVE_CYC;
        end
    end

    // ------------------------------------------------------------
    // Trigger modes
    // ------------------------------------------------------------
    always_comb begin
        mode[SRC_ZERO] = EII_TRIG_FALL;
        mode[SRC_ONE] = eii_trig_e'({1'b0, ctrl_q.irq_one_trigger_select});
        mode[SRC_THREE] = eii_trig_e'(ctrl_q.irq_three_trigger_select);
        mode[SRC_FOUR] = eii_trig_e'(ctrl_q.irq_four_trigger_select);
        mode[SRC_FIVE] = EII_TRIG_FALL;
    end

    // ------------------------------------------------------------
    // Per-pin filter and detector
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            eii_noise_filter u_filter (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(pins[g]),
                .sample_en_i(sample_en),
                .thresh_i(thresh[g]),
                .filt_o(filt[g]),
                .valid_o(valid[g])
            );

            eii_trigger_detect u_detect (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .filt_i(filt[g]),
                .valid_i(valid[g]),
                .mode_i(mode[g]),
                .event_o(trig_event[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt latches
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] latch_set;
    logic [NUM_SRC-1:0] enabled;

    // Shared pin events are dropped while the pin serves the port
    always_comb begin
        latch_set = trig_event;
        latch_set[SRC_ZERO] = trig_event[SRC_ZERO] & ctrl_q.shared_pin_function_select;
    end

    // Set wins over acceptance or software clear; a high level keeps
    // setting the latch again after each acceptance
    assign latch_d = (latch_q & ~(accept_i | sw_clear)) | latch_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Enable conditions per source
    always_comb begin
        enabled[SRC_ZERO] = enables_i.enable_flag_irq_zero & ctrl_q.shared_pin_function_select;
        enabled[SRC_ONE] = enables_i.enable_flag_irq_one;
        enabled[SRC_THREE] = enables_i.enable_flag_irq_three & enables_i.shared_level_source_select;
        enabled[SRC_FOUR] = enables_i.enable_flag_irq_four;
        enabled[SRC_FIVE] = enables_i.enable_flag_irq_five;
    end

    // Requests offered to the CPU; the master enable gates all of them
    assign request_o = latch_q & enabled & {NUM_SRC{enables_i.master_interrupt_enable}};
    assign latch_o = latch_q;
    // Port logic must already hold the pin as input before this rises
    assign shared_pin_function_o = ctrl_q.shared_pin_function_select;

endmodule : eii_top

`default_nettype wire

// ---- verif/eii_top_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none

module eii_top_assertions
    import eii_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire eii_enables_s enables_i,
    input wire logic [NUM_SRC-1:0] accept_i,
    input wire logic [NUM_SRC-1:0] latch_o,
    input wire logic [NUM_SRC-1:0] request_o,
    input wire logic shared_pin_function_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr_ctrl;
    logic wr_latch;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_ADDR;
    assign wr_latch = req && wb_we_i && wb_sel_i[0] && wb_adr_i == LATCH_ADDR;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_quiet: assert property (!req |=> !wb_ack_o) else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper bits set");
    a_req_latch: assert property ((request_o & ~latch_o) == '0) else $error("request without latch");
    a_req_master: assert property (|request_o |-> enables_i.master_interrupt_enable)
        else $error("request with master off");
    a_zero_gate: assert property (request_o[SRC_ZERO] |-> shared_pin_function_o
        && enables_i.enable_flag_irq_zero) else $error("zero request not gated");
    a_zero_blocked: assert property ($rose(latch_o[SRC_ZERO]) |-> $past(shared_pin_function_o))
        else $error("zero latched in port mode");
    // A latch may only drop after an accept pulse or a clearing write
    a_latch_hold: assert property ((($past(latch_o) & ~latch_o) != '0) |-> $past(|accept_i || wr_latch))
        else $error("latch dropped by itself");
    a_func_write: assert property ($changed(shared_pin_function_o) |-> $past(wr_ctrl))
        else $error("function select changed without write");
    a_reset_quiet: assert property ($fell(rst_i) |-> latch_o == '0 && !shared_pin_function_o && !wb_ack_o)
        else $error("outputs not cleared by reset");

    c_one_latched: cover property ($rose(latch_o[SRC_ONE]));
    c_request: cover property (|request_o);
    c_latch_clear: cover property (wr_latch && wb_ack_o);
endmodule : eii_top_assertions

bind eii_top eii_top_assertions i_eii_top_assertions (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .enables_i, .accept_i, .latch_o, .request_o,
    .shared_pin_function_o);

`default_nettype wire

// ---- verif/eii_src.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Signal sources on the five interrupt pins
// ------------------------------------------------------------
module eii_src
    import eii_pkg::*;
(
    input wire logic clk_i,
    output logic [NUM_SRC-1:0] pins_o
);
    // Falling-edge pins rest high, the others rest low
    initial pins_o = 5'h11;

    // Drive one pin to a level; caller stands on a rising edge
    task automatic set(input int idx, input logic lvl);
        pins_o[idx] <= lvl;
    endtask : set

    // A pulse of a given length in cycles, then back to the other level
    task automatic pulse(input int idx, input logic lvl, input int len);
        pins_o[idx] <= lvl;
        repeat (len) @(posedge clk_i);
        pins_o[idx] <= ~lvl;
    endtask : pulse
endmodule : eii_src

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import eii_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_we = 1'h0;
    logic [ADDR_W-1:0] wb_adr = '0;
    logic [31:0] wb_wdat = '0;
    logic [31:0] wb_rdat;
    logic [31:0] rdata;
    logic wb_ack;
    logic low_speed = 1'h0;
    logic tick = 1'h0;
    logic [2:0] tcnt = 3'h0;
    eii_enables_s en = 7'h00;
    logic [NUM_SRC-1:0] accept = 5'h00;
    logic [NUM_SRC-1:0] latch;
    logic [NUM_SRC-1:0] request;
    logic [NUM_SRC-1:0] pins;
    logic func;
    int num_errors = 0;
    int checked = 0;

    eii_src i_eii_src (.clk_i(clk_i), .pins_o(pins));
    eii_top i_eii_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .ext_irq_zero_i(pins[0]), .ext_irq_one_i(pins[1]), .ext_irq_three_i(pins[2]),
        .ext_irq_four_i(pins[3]), .ext_irq_five_i(pins[4]), .low_speed_mode_i(low_speed),
        .low_freq_tick_i(tick), .enables_i(en), .accept_i(accept), .latch_o(latch),
        .request_o(request), .shared_pin_function_o(func));

    // Clock, and a slow tick every 8 cycles standing for the low-frequency clock
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tcnt <= tcnt + 3'h1;
        tick <= (tcnt == 3'h7);
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One classic cycle; waits for ack, only the watchdog ends a hang
    task automatic bus(input logic we, input logic [ADDR_W-1:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1);
        rdata = wb_rdat;
        // Ack follows the taking edge by one cycle, so it is seen on the second edge
        check("ack delay", 32'(n), 32'h0000_0002);
        wb_cyc <= 1'h0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdc(input string what, input logic [ADDR_W-1:0] adr, input logic [31:0] exp);
        bus(1'h0, adr, 8'h00);
        check(what, rdata, exp);
    endtask : rdc

    // Master enable is dropped while the filters are reprogrammed
    task automatic wrc(input logic [7:0] d);
        logic m;
        m = en.master_interrupt_enable;
        en.master_interrupt_enable <= 1'h0;
        bus(1'h1, CTRL_ADDR, d);
        en.master_interrupt_enable <= m;
    endtask : wrc

    task automatic lc(input logic [4:0] e, input int w);
        repeat (w) @(posedge clk_i);
        check("latch", latch, e);
    endtask : lc

    task automatic clr;
        bus(1'h1, LATCH_ADDR, 8'h1f);
    endtask : clr

    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        check("func", func, 32'h0000_0000);
        rdc("ctrl", CTRL_ADDR, 32'h0000_0000);
        bus(1'h1, 10'h004, 8'hff);
        rdc("unmapped", 10'h004, 32'h0000_0000);
        i_eii_src.pulse(SRC_ZERO, 1'h0, 20);
        lc(5'h00, 12);
        en <= 7'h7f;
        @(posedge clk_i);
        wrc(8'h40);
        rdc("ctrl", CTRL_ADDR, 32'h0000_0040);
        check("func", func, 32'h0000_0001);
        i_eii_src.pulse(SRC_ZERO, 1'h0, 1);
        lc(5'h00, 12);
        i_eii_src.pulse(SRC_ZERO, 1'h0, 7);
        lc(5'h01, 12);
        check("request", request, 32'h0000_0001);
        accept <= 5'h01;
        @(posedge clk_i);
        accept <= 5'h00;
        lc(5'h00, 2);
        i_eii_src.pulse(SRC_FIVE, 1'h0, 1);
        lc(5'h00, 12);
        i_eii_src.pulse(SRC_FIVE, 1'h0, 7);
        lc(5'h10, 12);
        clr();
        lc(5'h00, 1);
        // Input one, long filter and rising edge
        i_eii_src.pulse(SRC_ONE, 1'h1, 40);
        lc(5'h00, 70);
        i_eii_src.pulse(SRC_ONE, 1'h1, 70);
        lc(5'h02, 4);
        clr();
        wrc(8'hc2);
        // The pending fall of the last pulse only gets through the short filter in time
        lc(5'h02, 26);
        clr();
        i_eii_src.pulse(SRC_ONE, 1'h1, 20);
        lc(5'h02, 24);
        clr();
        // Inputs three and four through every trigger mode
        wrc(8'h40);
        i_eii_src.pulse(SRC_THREE, 1'h1, 4);
        lc(5'h00, 16);
        for (int m = 0; m < 4; m++) begin
            wrc(8'h40 | 8'(m << 4) | 8'(m << 2));
            clr();
            i_eii_src.set(SRC_THREE, 1'h1);
            i_eii_src.set(SRC_FOUR, 1'h1);
            lc((m == 1) ? 5'h00 : 5'h0c, 20);
            clr();
            lc((m == 3) ? 5'h0c : 5'h00, 3);
            if (m == 3) begin
                check("request", request, 32'h0000_000c);
                en.shared_level_source_select <= 1'h0;
                @(posedge clk_i);
                check("request", request, 32'h0000_0008);
                en.shared_level_source_select <= 1'h1;
            end
            i_eii_src.set(SRC_THREE, 1'h0);
            i_eii_src.set(SRC_FOUR, 1'h0);
            lc((m == 0) ? 5'h00 : 5'h0c, 20);
            clr();
            lc(5'h00, 1);
        end
        // Slow mode, filters count the slow tick
        low_speed <= 1'h1;
        wrc(8'h40);
        i_eii_src.pulse(SRC_FIVE, 1'h0, 4);
        lc(5'h00, 60);
        i_eii_src.pulse(SRC_FIVE, 1'h0, 32);
        lc(5'h10, 50);
        clr();
        low_speed <= 1'h0;
        // High level mode with the pin already high at reset release
        i_eii_src.set(SRC_FOUR, 1'h1);
        rst_i <= 1'h1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wrc(8'h0c);
        lc(5'h00, 30);
        i_eii_src.pulse(SRC_FOUR, 1'h0, 20);
        lc(5'h08, 20);
        report_and_stop();
    end

    // Watchdog, well beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
